/* hdl/src_irq_pkg.sv */
package src_irq_pkg;
   localparam int NUM_CH = 3;
   localparam int NUM_COND = 4;
   // ********************************
   // Register offsets per channel
   // ********************************
   localparam logic [NUM_CH-1:0][7:0] ENABLE_OFS = {8'h11, 8'h09, 8'h01};
   localparam logic [NUM_CH-1:0][7:0] STATUS_OFS = {8'h12, 8'h0A, 8'h02};
   localparam logic [NUM_CH-1:0][7:0] ALARM_OFS = {8'h13, 8'h0B, 8'h03};
   // ********************************
   // Field positions and reset values
   // ********************************
   localparam int FIFO_LIMIT_BIT = 3;
   localparam int LOCK_LOST_BIT = 2;
   localparam int SIGNAL_LOST_BIT = 1;
   localparam int DRIVE_MON_BIT = 0;
   localparam logic [3:0] COND_RST = 4'h0;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [3:0] UNUSED_HI = 4'h0;

   typedef struct packed {
      logic fifo_limit_alarm;
      logic receive_lock_lost;
      logic receive_signal_lost;
      logic drive_monitor_output;
   } cond_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
endpackage

/* hdl/chan_change_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module chan_change_flags
   import src_irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire cond_type cond_in,
   input wire logic [3:0] enable,
   input wire logic rd_clear,
   output cond_type flags_ff,
   output cond_type live_ff
);
   logic [3:0] chg;
   cond_type nxt_flags;

   // ********************************
   // Change detection and sticky flags
   // ********************************
   assign chg = cond_in ^ live_ff;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         live_ff <= COND_RST;
      end else begin
         live_ff <= cond_in;
      end
   end

   always_comb begin
      nxt_flags = (flags_ff & ~{4{rd_clear}}) | (chg & enable);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         flags_ff <= COND_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // ********************************
   // Checks
   // ********************************
   sequence s_fl_declared;
      !live_ff.fifo_limit_alarm ##0 cond_in.fifo_limit_alarm ##0 enable[FIFO_LIMIT_BIT];
   endsequence
   sequence s_fl_cleared;
      live_ff.fifo_limit_alarm ##0 !cond_in.fifo_limit_alarm ##0 enable[FIFO_LIMIT_BIT];
   endsequence

   a_fl_declare_sets: assert property (@(posedge core_clk) disable iff (srst)
      s_fl_declared |=> flags_ff.fifo_limit_alarm)
      else $error("fifo limit declare did not set flag");
   a_fl_clear_sets: assert property (@(posedge core_clk) disable iff (srst)
      s_fl_cleared |=> flags_ff.fifo_limit_alarm)
      else $error("fifo limit clear did not set flag");
   a_disabled_no_set: assert property (@(posedge core_clk) disable iff (srst)
      (!enable[LOCK_LOST_BIT] && !flags_ff.receive_lock_lost) |=> !flags_ff.receive_lock_lost)
      else $error("lock lost flag set while disabled");
   a_read_clears_quiet: assert property (@(posedge core_clk) disable iff (srst)
      (rd_clear && chg == 4'h0) |=> flags_ff == COND_RST)
      else $error("read did not clear flags");
   a_change_beats_read: assert property (@(posedge core_clk) disable iff (srst)
      (rd_clear && chg[SIGNAL_LOST_BIT] && enable[SIGNAL_LOST_BIT]) |=> flags_ff.receive_signal_lost)
      else $error("change lost during read");
   a_flag_sticky: assert property (@(posedge core_clk) disable iff (srst)
      (flags_ff.drive_monitor_output && !rd_clear) |=> flags_ff.drive_monitor_output)
      else $error("drive monitor flag dropped without read");
endmodule
`default_nettype wire

/* hdl/source_interrupt_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module source_interrupt_status_regs
   import src_irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire reg_req_type reg_req,
   input wire cond_type [NUM_CH-1:0] cond_in,
   output logic [7:0] rd_data_ff,
   output logic rd_valid_ff
);
   logic [NUM_CH-1:0][3:0] enable_ff;
   logic [NUM_CH-1:0] rd_clear;
   cond_type [NUM_CH-1:0] flags;
   cond_type [NUM_CH-1:0] live;
   logic [NUM_CH-1:0][7:0] rd_term;
   logic [7:0] nxt_rd_data;

   // ********************************
   // Per-channel registers
   // ********************************
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         always_ff @(posedge core_clk) begin
            if (srst) begin
               enable_ff[ch] <= COND_RST;
            end else if (reg_req.wr && reg_req.addr == ENABLE_OFS[ch]) begin
               enable_ff[ch] <= reg_req.wdata[3:0];
            end
         end

         assign rd_clear[ch] = reg_req.rd && reg_req.addr == STATUS_OFS[ch];

         always_comb begin
            if (reg_req.addr == STATUS_OFS[ch]) begin
               rd_term[ch] = {UNUSED_HI, flags[ch]};
            end else if (reg_req.addr == ALARM_OFS[ch]) begin
               rd_term[ch] = {UNUSED_HI, live[ch]};
            end else if (reg_req.addr == ENABLE_OFS[ch]) begin
               rd_term[ch] = {UNUSED_HI, enable_ff[ch]};
            end else begin
               rd_term[ch] = REG_RST;
            end
         end

         chan_change_flags u_flags (
            .core_clk(core_clk),
            .srst(srst),
            .cond_in(cond_in[ch]),
            .enable(enable_ff[ch]),
            .rd_clear(rd_clear[ch]),
            .flags_ff(flags[ch]),
            .live_ff(live[ch])
         );
      end
   endgenerate

   // ********************************
   // Read data return
   // ********************************
   always_comb begin
      nxt_rd_data = REG_RST;
      for (int i = 0; i < NUM_CH; i++) begin
         nxt_rd_data = nxt_rd_data | rd_term[i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rd_data_ff <= REG_RST;
      end else if (reg_req.rd) begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= reg_req.rd;
      end
   end

   // ********************************
   // Checks
   // ********************************
   sequence s_fl_change_ch0;
      enable_ff[0][FIFO_LIMIT_BIT] && cond_in[0].fifo_limit_alarm != live[0].fifo_limit_alarm;
   endsequence
   sequence s_status_rd_ch0;
      reg_req.rd && reg_req.addr == STATUS_OFS[0];
   endsequence
   sequence s_lol_change_ch1;
      enable_ff[1][LOCK_LOST_BIT] && cond_in[1].receive_lock_lost != live[1].receive_lock_lost;
   endsequence
   sequence s_status_rd_ch1;
      reg_req.rd && reg_req.addr == STATUS_OFS[1];
   endsequence
   sequence s_status_rd_ch2;
      reg_req.rd && reg_req.addr == STATUS_OFS[2];
   endsequence
   sequence s_los_change_ch0;
      enable_ff[0][SIGNAL_LOST_BIT] && cond_in[0].receive_signal_lost != live[0].receive_signal_lost;
   endsequence
   sequence s_quiet_ch0;
      cond_in[0] == live[0];
   endsequence
   a_status_ch0_read: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == 8'h02) |=> (rd_data_ff == {4'h0, $past(flags[0])}) && rd_valid_ff)
      else $error("channel 0 status read wrong");
   a_status_ch1_read: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == 8'h0A) |=> rd_data_ff == {4'h0, $past(flags[1])})
      else $error("channel 1 status read wrong");
   a_status_ch2_clear: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == 8'h12 && cond_in[2] == live[2]) |=> flags[2] == 4'h0)
      else $error("channel 2 status not cleared by read");
   a_alarm_live_read: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == 8'h03) |=> rd_data_ff[3:0] == $past(live[0]))
      else $error("alarm status does not show live state");
   a_lock_live_ch1: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == 8'h0B) |=> rd_data_ff[2] == $past(cond_in[1].receive_lock_lost, 2))
      else $error("lock lost live state wrong");
   a_flag_bit3_path: assert property (@(posedge core_clk) disable iff (srst)
      s_fl_change_ch0 ##1 s_status_rd_ch0 |=> rd_data_ff[FIFO_LIMIT_BIT])
      else $error("fifo limit change not seen in read");
   a_flag_bit2_path: assert property (@(posedge core_clk) disable iff (srst)
      s_lol_change_ch1 ##1 s_status_rd_ch1 |=> rd_data_ff[LOCK_LOST_BIT])
      else $error("lock lost change not seen in read");
   a_bit1_bit0_flags: assert property (@(posedge core_clk) disable iff (srst)
      (enable_ff[0][1:0] == 2'h0 && flags[0][1:0] == 2'h0) |=> flags[0][1:0] == 2'h0)
      else $error("low flags set while disabled");
   a_drive_mon_set: assert property (@(posedge core_clk) disable iff (srst)
      (enable_ff[2][0] && cond_in[2].drive_monitor_output != live[2].drive_monitor_output) |=> flags[2][0])
      else $error("drive monitor change not flagged");
   a_read_keeps_event: assert property (@(posedge core_clk) disable iff (srst)
      (rd_clear[0] && enable_ff[0][3] && cond_in[0].fifo_limit_alarm != live[0].fifo_limit_alarm)
      |=> flags[0].fifo_limit_alarm [*1] ##1 1'b1)
      else $error("event coinciding with read lost");
   a_unmapped_zero: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == 8'h00) |=> rd_data_ff == 8'h00)
      else $error("unmapped read not zero");

   // ********************************
   // Read port, flag, enable write and reset checks
   // ********************************
   a_status_ch2_read: assert property (@(posedge core_clk) disable iff (srst)
      s_status_rd_ch2 |=> rd_data_ff == {UNUSED_HI, $past(flags[2])})
      else $error("channel 2 status read wrong");
   a_read_clears_ch0: assert property (@(posedge core_clk) disable iff (srst)
      s_status_rd_ch0 ##0 s_quiet_ch0 |=> flags[0] == COND_RST)
      else $error("channel 0 status not cleared by read");
   a_read_clears_ch1: assert property (@(posedge core_clk) disable iff (srst)
      s_status_rd_ch1 ##0 cond_in[1] == live[1] |=> flags[1] == COND_RST)
      else $error("channel 1 status not cleared by read");
   a_los_change_set: assert property (@(posedge core_clk) disable iff (srst)
      s_los_change_ch0 |=> flags[0].receive_signal_lost)
      else $error("signal lost change not flagged");
   a_lol_keeps_read: assert property (@(posedge core_clk) disable iff (srst)
      s_status_rd_ch1 ##0 s_lol_change_ch1 |=> flags[1].receive_lock_lost)
      else $error("lock lost change lost during read");
   a_lol_no_spurious: assert property (@(posedge core_clk) disable iff (srst)
      (!flags[1].receive_lock_lost && cond_in[1].receive_lock_lost == live[1].receive_lock_lost)
      |=> !flags[1].receive_lock_lost)
      else $error("lock lost flag set without change");
   a_fl_alarm_ch2: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == ALARM_OFS[2]) |=> rd_data_ff[FIFO_LIMIT_BIT] == $past(live[2].fifo_limit_alarm))
      else $error("fifo limit live state wrong");
   a_lol_alarm_ch0: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == ALARM_OFS[0]) |=> rd_data_ff[LOCK_LOST_BIT] == $past(live[0].receive_lock_lost))
      else $error("lock lost live state wrong on channel 0");
   a_upper_zero: assert property (@(posedge core_clk) disable iff (srst)
      reg_req.rd |=> rd_data_ff[7:4] == UNUSED_HI)
      else $error("unused read bits not zero");
   a_valid_pulse: assert property (@(posedge core_clk) disable iff (srst)
      reg_req.rd |=> rd_valid_ff)
      else $error("read valid missing");
   a_valid_idle: assert property (@(posedge core_clk) disable iff (srst)
      !reg_req.rd |=> !rd_valid_ff)
      else $error("read valid without read");
   a_data_holds: assert property (@(posedge core_clk) disable iff (srst)
      !reg_req.rd |=> $stable(rd_data_ff))
      else $error("read data changed without read");
   a_enable_write: assert property (@(posedge core_clk) disable iff (srst)
      (reg_req.wr && reg_req.addr == ENABLE_OFS[1]) |=> enable_ff[1] == $past(reg_req.wdata[3:0]))
      else $error("enable write not taken");
   a_reset_clears: assert property (@(posedge core_clk)
      srst |=> flags == '0 && enable_ff == '0 && rd_data_ff == REG_RST && !rd_valid_ff)
      else $error("reset did not clear state");

   // ********************************
   // Per-channel checks
   // ********************************
   genvar cc;
   generate
      for (cc = 0; cc < NUM_CH; cc++) begin : g_chk
         sequence s_any_change;
            ((cond_in[cc] ^ live[cc]) & enable_ff[cc]) != 4'h0;
         endsequence
         sequence s_status_read;
            reg_req.rd && reg_req.addr == STATUS_OFS[cc];
         endsequence
         sequence s_alarm_read;
            reg_req.rd && reg_req.addr == ALARM_OFS[cc];
         endsequence
         a_status_layout: assert property (@(posedge core_clk) disable iff (srst)
            s_status_read |=> rd_data_ff == {UNUSED_HI, $past(flags[cc])})
            else $error("status read does not match flags");
         a_alarm_layout: assert property (@(posedge core_clk) disable iff (srst)
            s_alarm_read |=> rd_data_ff == {UNUSED_HI, $past(live[cc])})
            else $error("alarm status does not match live state");
         a_set_on_change: assert property (@(posedge core_clk) disable iff (srst)
            s_any_change |=> (flags[cc] | ~$past((cond_in[cc] ^ live[cc]) & enable_ff[cc])) == 4'hF)
            else $error("enabled change not flagged");
         a_no_set_quiet: assert property (@(posedge core_clk) disable iff (srst)
            (flags[cc] == COND_RST && ((cond_in[cc] ^ live[cc]) & enable_ff[cc]) == 4'h0) |=> flags[cc] == COND_RST)
            else $error("flag set without enabled change");
         a_sticky_no_read: assert property (@(posedge core_clk) disable iff (srst)
            !rd_clear[cc] |=> (flags[cc] & $past(flags[cc])) == $past(flags[cc]))
            else $error("flag dropped without read");
         a_live_follows: assert property (@(posedge core_clk) disable iff (srst)
            1'b1 |=> live[cc] == $past(cond_in[cc]))
            else $error("live copy does not follow condition");
         a_read_clear_quiet: assert property (@(posedge core_clk) disable iff (srst)
            s_status_read ##0 ((cond_in[cc] ^ live[cc]) & enable_ff[cc]) == 4'h0 |=> flags[cc] == COND_RST)
            else $error("quiet read did not clear flags");
      end
   endgenerate
endmodule
`default_nettype wire

/* dv/cond_source.sv */
`timescale 1ns/1ps
`default_nettype none
module cond_source
   import src_irq_pkg::*;
(
   input wire logic core_clk,
   input wire cond_type [NUM_CH-1:0] want,
   output cond_type [NUM_CH-1:0] cond_in
);
   // ********************************
   // Condition detectors
   // ********************************
   cond_type [NUM_CH-1:0] want_ff;

   // Request taken at the rising edge, so the falling edge update never races the bench
   always_ff @(posedge core_clk) begin
      want_ff <= want;
   end

   // Levels move only at the falling edge, like same-clock detector logic
   always_ff @(negedge core_clk) begin
      cond_in <= want_ff;
   end
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import src_irq_pkg::*;
;
   logic core_clk;
   logic srst;
   reg_req_type req;
   cond_type [NUM_CH-1:0] want;
   cond_type [NUM_CH-1:0] cond_in;
   logic [7:0] rd_data_ff;
   logic rd_valid_ff;
   logic [7:0] d;
   logic [3:0] m;
   int miscompares = 0;
   int n_compared = 0;

   source_interrupt_status_regs dut_u (.core_clk(core_clk), .srst(srst), .reg_req(req), .cond_in(cond_in),
      .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));
   cond_source src_u (.core_clk(core_clk), .want(want), .cond_in(cond_in));

   // ********************************
   // Clock and tasks
   // ********************************
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = v;
      @(negedge core_clk);
      req.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge core_clk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge core_clk);
      req.rd = 1'b0;
      chk({7'h00, rd_valid_ff}, 8'h01);
      v = rd_data_ff;
   endtask

   task automatic complete_run();
      $display("Compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      miscompares++;
      complete_run();
   end

   // ********************************
   // Tests
   // ********************************
   initial begin
      srst = 1'b1;
      req = '0;
      want = '0;
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      srst = 1'b0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         rd(STATUS_OFS[ch], d);
         chk(d, REG_RST);
      end
      rd(8'h20, d);
      chk(d, 8'h00);
      $display("Test reset values done");
      for (int ch = 0; ch < NUM_CH; ch++) begin
         wr(ENABLE_OFS[ch], 8'h0F);
         for (int b = 0; b < NUM_COND; b++) begin
            m = 4'h1 << b;
            want[ch] = cond_type'(m);
            repeat (2) @(negedge core_clk);
            rd(STATUS_OFS[ch], d);
            chk(d, {4'h0, m});
            rd(STATUS_OFS[ch], d);
            chk(d, 8'h00);
            rd(ALARM_OFS[ch], d);
            chk(d, {4'h0, m});
            want[ch] = '0;
            repeat (2) @(negedge core_clk);
            rd(STATUS_OFS[ch], d);
            chk(d, {4'h0, m});
         end
      end
      $display("Test change flags done");
      wr(ENABLE_OFS[0], 8'h00);
      want[0] = cond_type'(4'hF);
      repeat (2) @(negedge core_clk);
      rd(STATUS_OFS[0], d);
      chk(d, 8'h00);
      rd(ALARM_OFS[0], d);
      chk(d, 8'h0F);
      $display("Test disabled change done");
      @(negedge core_clk);
      want[1] = cond_type'(4'h4);
      rd(STATUS_OFS[1], d);
      chk(d, 8'h00);
      rd(STATUS_OFS[1], d);
      chk(d, 8'h04);
      $display("Test change during read done");
      want[2] = cond_type'(4'h1);
      repeat (2) @(negedge core_clk);
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      chk(rd_data_ff, REG_RST);
      rd(STATUS_OFS[2], d);
      chk(d, REG_RST);
      rd(ENABLE_OFS[2], d);
      chk(d, REG_RST);
      $display("Test mid-run reset done");
      complete_run();
   end
endmodule
`default_nettype wire
